// ==== logic/add_instruction_execute.sv ====
// Decode and execute of the two add instructions of the core
// Function
// - Literal add: literal plus accumulator to accumulator, flags, one cycle
// - Register add: accumulator plus file register, flags updated, one cycle
// - Destination bit zero writes accumulator, one writes file register
// - Bank bit zero, extended set, address up to 95: indexed offset mode
`timescale 1ns/1ps
`default_nettype none
module add_instruction_execute (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic extendedEnable,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] indexBase,
  input wire logic [7:0] fileReadData,
  output logic [11:0] fileAddr,
  output logic fileWrite,
  output logic [7:0] fileWriteData,
  output logic [11:0] fileWriteAddr,
  output logic [7:0] accumulator,
  output logic [4:0] statusFlags,
  output logic flagsWrite,
  output logic indexedMode,
  output logic execDone
);
  typedef struct packed {
    logic [7:0] acc;
    logic [4:0] flags;
    logic [11:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic fwr;
    logic idx;
    logic done;
  } state_s;

  state_s stateReg, stateNext;
  logic isLit, isFile, dest, bankBit, useIdx;
  logic [7:0] fAddr, opB, sum;
  logic [4:0] aluFlags;
  logic [8:0] expSum, expLow;

  // Reference sum kept apart from the adder so the checks do not echo it
  function automatic logic [8:0] refSum(input logic [7:0] x,
      input logic [7:0] y);
    refSum = {1'b0, x} + {1'b0, y};
  endfunction

  function automatic logic [11:0] resolveAddr(input logic [7:0] f,
      input logic a, input logic idx, input logic [3:0] bank,
      input logic [11:0] base);
    if (idx) begin
      resolveAddr = base + {4'h0, f};
    end else if (a) begin
      resolveAddr = {bank, f};
    end else if (f < add_exec_pkg::ACCESS_SPLIT) begin
      resolveAddr = {4'h0, f};
    end else begin
      resolveAddr = {add_exec_pkg::ACCESS_HIGH_BANK, f};
    end
  endfunction

  add_unit u_add (
    .opA(stateReg.acc),
    .opB(opB),
    .sum(sum),
    .flags(aluFlags)
  );

  always_comb begin
    isLit = instrValid && instrWord[add_exec_pkg::OPC_HI_MSB:
      add_exec_pkg::OPC_HI_LSB] == add_exec_pkg::OPC_ADD_LITERAL;
    isFile = instrValid && instrWord[add_exec_pkg::OPC_HI_MSB:
      add_exec_pkg::OPC_FILE_LSB] == add_exec_pkg::OPC_ADD_FILE;
    dest = instrWord[add_exec_pkg::DEST_BIT];
    bankBit = instrWord[add_exec_pkg::BANK_BIT];
    fAddr = instrWord[7:0];
    useIdx = !bankBit && extendedEnable &&
      fAddr <= add_exec_pkg::INDEXED_LIMIT;
    // Operand read is combinational so the add completes in one cycle
    opB = isLit ? instrWord[7:0] : fileReadData;
    // Check-side sums, read by the flag assertions only
    expSum = refSum(stateReg.acc, opB);
    expLow = refSum({4'h0, stateReg.acc[3:0]}, {4'h0, opB[3:0]});
  end

  // Address goes out combinationally too: the file read must land this cycle
  assign fileAddr = resolveAddr(fAddr, bankBit, useIdx,
    bank_select_register, indexBase);

  always_comb begin
    stateNext = stateReg;
    stateNext.wr = 1'b0;
    stateNext.fwr = 1'b0;
    stateNext.done = 1'b0;
    stateNext.idx = 1'b0;
    if (isLit) begin
      stateNext.acc = sum;
      stateNext.flags = aluFlags;
      stateNext.fwr = 1'b1;
      stateNext.done = 1'b1;
    end else if (isFile) begin
      stateNext.flags = aluFlags;
      stateNext.fwr = 1'b1;
      stateNext.done = 1'b1;
      stateNext.idx = useIdx;
      stateNext.addr = fileAddr;
      if (dest) begin
        stateNext.wr = 1'b1;
        stateNext.wdata = sum;
      end else begin
        stateNext.acc = sum;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= '{acc: add_exec_pkg::ACC_RESET,
        flags: add_exec_pkg::FLAGS_RESET, addr: add_exec_pkg::ADDR_RESET,
        wr: 1'b0, wdata: add_exec_pkg::WDATA_RESET, fwr: 1'b0, idx: 1'b0,
        done: 1'b0};
    end else begin
      stateReg <= stateNext;
    end
  end

  assign accumulator = stateReg.acc;
  assign statusFlags = stateReg.flags;
  assign fileWrite = stateReg.wr;
  assign fileWriteData = stateReg.wdata;
  // Write address is held from the add, fileAddr already serves the next read
  assign fileWriteAddr = stateReg.addr;
  assign flagsWrite = stateReg.fwr;
  assign indexedMode = stateReg.idx;
  assign execDone = stateReg.done;

  a_literal_sum: assert property (@(posedge clk) disable iff (!rst_n)
    isLit |=> accumulator == $past(stateReg.acc) + $past(instrWord[7:0])
      && execDone && !fileWrite)
    else $error("Literal add result wrong");
  a_file_to_acc: assert property (@(posedge clk) disable iff (!rst_n)
    isFile && !dest |=> accumulator == $past(stateReg.acc) +
      $past(fileReadData) && !fileWrite)
    else $error("Register add to accumulator wrong");
  a_file_to_reg: assert property (@(posedge clk) disable iff (!rst_n)
    isFile && dest |=> fileWrite && accumulator == $past(stateReg.acc)
      && fileWriteData == $past(stateReg.acc) + $past(fileReadData))
    else $error("Register add writeback wrong");
  a_flags_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (isLit || isFile) |=> flagsWrite &&
      statusFlags[add_exec_pkg::FLAG_ZERO] == ($past(expSum[7:0]) == 8'h00))
    else $error("Zero flag wrong");
  a_indexed_sel: assert property (@(posedge clk) disable iff (!rst_n)
    isFile |=> indexedMode == ($past(!bankBit) && $past(extendedEnable)
      && $past(fAddr) <= add_exec_pkg::INDEXED_LIMIT))
    else $error("Indexed mode selection wrong");
  a_bank_addr: assert property (@(posedge clk) disable iff (!rst_n)
    isFile && bankBit |-> fileAddr == {bank_select_register, fAddr})
    else $error("Bank select addressing wrong");
  a_access_addr: assert property (@(posedge clk) disable iff (!rst_n)
    isFile && !bankBit && !useIdx |-> fileAddr[7:0] == fAddr)
    else $error("Access bank addressing wrong");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !(isLit || isFile) |=> !execDone && !fileWrite &&
      $stable(accumulator))
    else $error("Activity without an add instruction");

  // Flag checks work from expSum and expLow, never from the adder outputs
  a_carry_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (isLit || isFile) |=> statusFlags[add_exec_pkg::FLAG_CARRY] ==
      $past(expSum[8]))
    else $error("Carry flag wrong");
  a_digit_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (isLit || isFile) |=> statusFlags[add_exec_pkg::FLAG_DIGIT] ==
      $past(expLow[4]))
    else $error("Digit carry flag wrong");
  a_neg_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (isLit || isFile) |=> statusFlags[add_exec_pkg::FLAG_NEG] ==
      $past(expSum[7]))
    else $error("Negative flag wrong");
  a_ovf_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (isLit || isFile) |=> statusFlags[add_exec_pkg::FLAG_OVF] ==
      $past(stateReg.acc[7] == opB[7] && expSum[7] != stateReg.acc[7]))
    else $error("Overflow flag wrong");
  a_flags_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(isLit || isFile) |=> !flagsWrite && !indexedMode &&
      $stable(statusFlags))
    else $error("Flags moved without an add");

  // Destination and address checks
  a_dest_select: assert property (@(posedge clk) disable iff (!rst_n)
    isFile |=> fileWrite == $past(dest))
    else $error("Destination select wrong");
  a_write_addr: assert property (@(posedge clk) disable iff (!rst_n)
    isFile && dest |=> fileWriteAddr == $past(fileAddr))
    else $error("Write address not held from the add");
  a_lit_direct: assert property (@(posedge clk) disable iff (!rst_n)
    isLit |=> !indexedMode && !fileWrite && flagsWrite)
    else $error("Literal add touched the file");
  a_index_addr: assert property (@(posedge clk) disable iff (!rst_n)
    isFile && useIdx |-> fileAddr == indexBase + {4'h0, fAddr})
    else $error("Indexed address wrong");
  a_no_extended: assert property (@(posedge clk) disable iff (!rst_n)
    isFile && !extendedEnable |=> !indexedMode)
    else $error("Indexed mode without extended set");
  a_bank_direct: assert property (@(posedge clk) disable iff (!rst_n)
    isFile && bankBit |=> !indexedMode)
    else $error("Indexed mode with bank bit set");
  a_access_low: assert property (@(posedge clk) disable iff (!rst_n)
    isFile && !bankBit && !useIdx && fAddr < add_exec_pkg::ACCESS_SPLIT
      |-> fileAddr[11:8] == 4'h0)
    else $error("Access bank low half wrong");
  a_access_high: assert property (@(posedge clk) disable iff (!rst_n)
    isFile && !bankBit && !useIdx && fAddr >= add_exec_pkg::ACCESS_SPLIT
      |-> fileAddr[11:8] == add_exec_pkg::ACCESS_HIGH_BANK)
    else $error("Access bank high half wrong");
endmodule
`default_nettype wire

// ==== logic/add_exec_pkg.sv ====
// Constants for the add instruction decode and execute block
package add_exec_pkg;
  localparam logic [7:0] OPC_ADD_LITERAL = 8'h0f;
  localparam logic [5:0] OPC_ADD_FILE = 6'h09;
  localparam int OPC_HI_MSB = 15;
  localparam int OPC_HI_LSB = 8;
  localparam int OPC_FILE_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DIGIT = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_OVF = 3;
  localparam int FLAG_NEG = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [7:0] WDATA_RESET = 8'h00;
endpackage

// ==== logic/add_unit.sv ====
// Eight-bit adder with status flag generation
`timescale 1ns/1ps
`default_nettype none
module add_unit (
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  output logic [7:0] sum,
  output logic [4:0] flags
);
  logic [8:0] full;
  logic [4:0] low;
  always_comb begin
    full = {1'b0, opA} + {1'b0, opB};
    low = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
    sum = full[7:0];
    flags = '0;
    flags[add_exec_pkg::FLAG_CARRY] = full[8];
    flags[add_exec_pkg::FLAG_DIGIT] = low[4];
    flags[add_exec_pkg::FLAG_ZERO] = (full[7:0] == 8'h00);
    flags[add_exec_pkg::FLAG_OVF] = (opA[7] == opB[7]) && (full[7] != opA[7]);
    flags[add_exec_pkg::FLAG_NEG] = full[7];
  end
endmodule
`default_nettype wire

// ==== verif/tb_add_instruction_execute.sv ====
// Self-checking bench for the add instruction decode and execute block
`timescale 1ns/1ps
`default_nettype none
module tb_add_instruction_execute;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic extendedEnable = 1'b0;
  logic [3:0] bankSelect = 4'ha;
  logic [11:0] indexBase = 12'h300;
  logic [7:0] fileReadData = 8'h00;
  logic [11:0] fileAddr;
  logic fileWrite;
  logic [7:0] fileWriteData;
  logic [11:0] fileWriteAddr;
  logic [7:0] accumulator;
  logic [4:0] statusFlags;
  logic flagsWrite;
  logic indexedMode;
  logic execDone;
  logic [7:0] accM = 8'h00;
  int mismatches = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  add_instruction_execute u_add_instruction_execute (.clk(clk),
    .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
    .extendedEnable(extendedEnable), .bank_select_register(bankSelect),
    .indexBase(indexBase), .fileReadData(fileReadData),
    .fileAddr(fileAddr), .fileWrite(fileWrite),
    .fileWriteData(fileWriteData), .fileWriteAddr(fileWriteAddr),
    .accumulator(accumulator),
    .statusFlags(statusFlags), .flagsWrite(flagsWrite),
    .indexedMode(indexedMode), .execDone(execDone));
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One add; model keeps its own accumulator, flags worked out here
  task automatic op(input logic [15:0] w, input logic [7:0] rd,
      input logic [11:0] ea, input logic ix);
    logic [7:0] b;
    logic [8:0] s;
    logic lit;
    logic wr;
    lit = (w[15:8] === 8'h0f);
    wr = !lit && w[9];
    b = lit ? w[7:0] : rd;
    s = {1'b0, accM} + {1'b0, b};
    instrWord = w;
    fileReadData = rd;
    instrValid = 1'b1;
    #1;
    if (!lit)
      check("fileAddr", {4'h0, fileAddr}, {4'h0, ea});
    @(posedge clk);
    #1;
    check("execDone", {15'h0, execDone}, 16'h0001);
    check("flagsWrite", {15'h0, flagsWrite}, 16'h0001);
    check("flags", {11'h0, statusFlags}, {11'h0, s[7],
      (accM[7] == b[7]) && (s[7] != accM[7]), s[7:0] == 8'h00,
      ({1'b0, accM[3:0]} + {1'b0, b[3:0]}) > 5'h0f, s[8]});
    check("indexedMode", {15'h0, indexedMode}, {15'h0, ix});
    check("fileWrite", {15'h0, fileWrite}, {15'h0, wr});
    if (wr) begin
      check("fileWriteData", {8'h0, fileWriteData}, {8'h0, s[7:0]});
      check("fileWriteAddr", {4'h0, fileWriteAddr}, {4'h0, ea});
    end else begin
      accM = s[7:0];
    end
    check("accumulator", {8'h0, accumulator}, {8'h0, accM});
  endtask
  // Word that must not execute: no pulse, accumulator held
  task automatic refuse(input logic [15:0] w, input logic v);
    instrWord = w;
    instrValid = v;
    @(posedge clk);
    #1;
    check("execDone", {15'h0, execDone}, 16'h0000);
    check("fileWrite", {15'h0, fileWrite}, 16'h0000);
    check("flagsWrite", {15'h0, flagsWrite}, 16'h0000);
    check("accumulator", {8'h0, accumulator}, {8'h0, accM});
  endtask
  initial begin
    #500000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    check("acc reset", {8'h0, accumulator}, 16'h0000);
    check("flags reset", {11'h0, statusFlags}, 16'h0000);
    rst_n = 1'b1;
    // Back to back literal and register adds through sign, digit and carry limits
    op(16'h0f15, 8'h00, 12'h000, 1'b0);
    op(16'h0f10, 8'h00, 12'h000, 1'b0);
    op(16'h0f5b, 8'h00, 12'h000, 1'b0);
    op(16'h0f80, 8'h00, 12'h000, 1'b0);
    op(16'h2533, 8'hc2, 12'ha33, 1'b0);
    op(16'h265f, 8'h17, 12'h05f, 1'b0);
    op(16'h2460, 8'h01, 12'hf60, 1'b0);
    extendedEnable = 1'b1;
    op(16'h265f, 8'h02, 12'h35f, 1'b1);
    op(16'h2400, 8'hff, 12'h300, 1'b1);
    op(16'h2460, 8'h7f, 12'hf60, 1'b0);
    op(16'h2700, 8'h80, 12'ha00, 1'b0);
    refuse(16'h0e55, 1'b1);
    refuse(16'h2055, 1'b1);
    refuse(16'h0f01, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
